// [hw/toc_timer.sv]
// Timer counter, stop controls, fast flag clear and compare output control
// Behaviour
// R01: Channel 7 compare copies data bits under mask
// R02: Main counter is sixteen bits, counting up
// R03: Software reads the counter as one word
// R04: Counter writes only take effect in test mode
// R05: First count after a write may vary
// R06: Timer enable off stops timer and counter
// R07: No divide-by-64 tick while timer inactive
// R08: Stop-in-wait halts timer and accumulator
// R09: Stop-in-freeze halts counter, accumulator keeps running
// R10: Fast clear: channel access clears channel flag
// R11: Fast clear: counter access clears overflow flag
// R12: Fast clear: accumulator count access clears flags
// R13: Overflow toggle beats force, yields channel 7
// R14: Mode or level set makes pin output
// R15: Mode and level select compare action
// R16: Software clears mask bit for own action
// R17: Software settings for independent pulse accumulator
// R18: Channel 7 compare wins over channels 6..0
// R19: Counter increments per tick, wraps at top
`timescale 1ns/100ps

module toc_timer #(
    parameter int CHANNELS = 8 // Compare channels
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device operating modes
    input wire logic test_mode_i,
    input wire logic wait_mode_i,
    input wire logic freeze_mode_i,
    // Channel comparators and accumulator
    input wire logic [7:0] compare_hit_i,
    output logic [7:0] chan_flag_clr_o,
    output logic accum_flag_clr_o,
    output logic accum_tick_o,
    output logic accum_run_o,
    // Counter view
    output logic [15:0] count_o,
    output logic count_tick_o,
    // Timer port pins
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CHANNELS != 8) begin : g_bad_channels
        $error("toc_timer: register layout serves exactly eight channels");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] capture_sel_r; // One means output compare
    logic [7:0] ch7_override_mask_r; // Channel 7 override per pin
    logic [7:0] ch7_data_bits_r; // Levels pushed by channel 7
    logic [7:0] overflow_toggle_bits_r; // Toggle on overflow per channel
    logic [15:0] action_r; // Mode/level pairs, channel 7 at top
    logic [2:0] prescale_r; // Prescaler select
    toc_pkg::toc_ctrl_t ctrl_r; // Enable and stop controls
    logic [15:0] free_counter_r; // Main up counter
    logic overflow_flag_r; // Set on wrap, sticky
    logic [toc_pkg::IRQ_BITS-1:0] irq_stat_r; // Sticky events
    logic [toc_pkg::IRQ_BITS-1:0] irq_mask_r; // Interrupt enables
    logic [7:0] compare_output_line_r; // Compare output lines
    logic ack_r; // Bus acknowledge
    logic [31:0] dat_r; // Read data
    logic [7:0] chan_clr_r; // Channel flag clear pulses
    logic acc_clr_r; // Accumulator flag clear pulse

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire [5:0] idx_w = adr_i[7:2];
    wire req_w = cyc_i && stb_i;
    wire take_w = req_w && !ack_r; // First cycle: data and ack latched
    wire wr_w = req_w && we_i && ack_r && sel_i[0]; // Write lands with ack
    wire wr_word_w = req_w && we_i && ack_r && (sel_i[1:0] == 2'b11);
    wire hit_cap_sel_w = (idx_w == toc_pkg::IDX_CAPTURE_SEL);
    wire hit_force_w = (idx_w == toc_pkg::IDX_FORCE);
    wire hit_mask_w = (idx_w == toc_pkg::IDX_CH7_MASK);
    wire hit_data_w = (idx_w == toc_pkg::IDX_CH7_DATA);
    wire hit_cnt_hi_w = (idx_w == toc_pkg::IDX_COUNT_HIGH);
    wire hit_cnt_lo_w = (idx_w == toc_pkg::IDX_COUNT_LOW);
    wire hit_cnt_wd_w = (idx_w == toc_pkg::IDX_COUNT_WORD);
    wire hit_ctrl_w = (idx_w == toc_pkg::IDX_SYS_CTRL1);
    wire hit_tov_w = (idx_w == toc_pkg::IDX_OVF_TOGGLE);
    wire hit_act_hi_w = (idx_w == toc_pkg::IDX_ACTION_HI);
    wire hit_act_lo_w = (idx_w == toc_pkg::IDX_ACTION_LO);
    wire hit_presc_w = (idx_w == toc_pkg::IDX_PRESCALE);
    wire hit_ovf_w = (idx_w == toc_pkg::IDX_OVF_FLAG);
    wire hit_stat_w = (idx_w == toc_pkg::IDX_IRQ_STATUS);
    wire hit_imask_w = (idx_w == toc_pkg::IDX_IRQ_MASK);
    wire hit_chan_w = (idx_w >= toc_pkg::IDX_CHAN_FIRST) && (idx_w <= toc_pkg::IDX_CHAN_LAST);
    wire hit_acc_w = (idx_w == toc_pkg::IDX_ACC_CNT_HI) || (idx_w == toc_pkg::IDX_ACC_CNT_LO);
    wire hit_cnt_any_w = hit_cnt_hi_w || hit_cnt_lo_w || hit_cnt_wd_w;
    wire [2:0] chan_w = idx_w[3:1]; // Two byte registers per channel

    // Read mux: unmapped and write-only locations read as zero
    logic [31:0] rd_w;
    assign rd_w = hit_cap_sel_w ? {24'h0, capture_sel_r} :
                  hit_mask_w ? {24'h0, ch7_override_mask_r} :
                  hit_data_w ? {24'h0, ch7_data_bits_r} :
                  hit_cnt_hi_w ? {24'h0, free_counter_r[15:8]} :
                  hit_cnt_lo_w ? {24'h0, free_counter_r[7:0]} :
                  hit_cnt_wd_w ? {16'h0, free_counter_r} :
                  hit_ctrl_w ? {24'h0, ctrl_r, 4'h0} :
                  hit_tov_w ? {24'h0, overflow_toggle_bits_r} :
                  hit_act_hi_w ? {24'h0, action_r[15:8]} :
                  hit_act_lo_w ? {24'h0, action_r[7:0]} :
                  hit_presc_w ? {29'h0, prescale_r} :
                  hit_ovf_w ? {24'h0, overflow_flag_r, 7'h00} :
                  hit_stat_w ? {30'h0, irq_stat_r} :
                  hit_imask_w ? {30'h0, irq_mask_r} :
                  32'h0000_0000;

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    wire wait_stop_w = wait_mode_i && ctrl_r.stop_in_wait; // [R08]
    wire frz_stop_w = freeze_mode_i && ctrl_r.stop_in_freeze; // [R09]
    wire presc_run_w = ctrl_r.timer_on && !wait_stop_w; // [R06] [R07] [R08]
    wire cnt_run_w = presc_run_w && !frz_stop_w; // [R09]
    wire presc_tick_w;
    wire div64_w;

    toc_prescaler #(
        .DIV_LOG_MAX(toc_pkg::PRESC_MAX_LOG)
    ) u_presc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(presc_run_w),
        .select_i(prescale_r),
        .tick_o(presc_tick_w),
        .div64_o(div64_w)
    );

    // Accumulator clock dies with the prescaler, freeze leaves it alone
    assign accum_tick_o = div64_w; // [R07]
    assign accum_run_o = !wait_stop_w; // [R08] [R09]

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    wire cnt_step_w = cnt_run_w && presc_tick_w; // [R19]
    wire wrap_w = cnt_step_w && (free_counter_r == toc_pkg::COUNT_TOP); // [R19]
    wire test_wr_w = wr_w && test_mode_i; // [R04]
    logic [15:0] counter_nxt;

    // Test-mode loads are not tied to the prescaler phase, so the next
    // period can run short or long; cheaper than resyncing the chain
    always_comb begin
        counter_nxt = free_counter_r;
        if (test_wr_w && hit_cnt_wd_w && wr_word_w) begin
            counter_nxt = dat_i[15:0]; // [R04] [R05] [R03]
        end else if (test_wr_w && hit_cnt_hi_w) begin
            counter_nxt = {dat_i[7:0], free_counter_r[7:0]}; // [R04] [R05]
        end else if (test_wr_w && hit_cnt_lo_w) begin
            counter_nxt = {free_counter_r[15:8], dat_i[7:0]}; // [R04] [R05]
        end else if (cnt_step_w) begin
            counter_nxt = free_counter_r + 16'h0001; // [R02] [R19]
        end
    end

    // Counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            free_counter_r <= toc_pkg::RST_COUNT;
        end else begin
            free_counter_r <= counter_nxt;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag and fast flag clear
    // ------------------------------------------------------------
    wire ack_go_w = req_w && ack_r; // Access completes this edge
    wire ovf_sw_clr_w = wr_w && hit_ovf_w && dat_i[toc_pkg::OVF_FLAG_BIT];
    wire ovf_fast_clr_w = ack_go_w && ctrl_r.fast_flag_clear && hit_cnt_any_w; // [R11]

    // Set wins over any clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_r <= 1'b0;
        end else if (wrap_w) begin
            overflow_flag_r <= 1'b1;
        end else if (ovf_sw_clr_w || ovf_fast_clr_w) begin
            overflow_flag_r <= 1'b0; // [R11]
        end
    end

    // Pulses toward channel and accumulator flag logic, one per access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_clr_r <= 8'h00;
            acc_clr_r <= 1'b0;
        end else begin
            chan_clr_r <= 8'h00;
            acc_clr_r <= ack_go_w && ctrl_r.fast_flag_clear && hit_acc_w; // [R12]
            // Capture channels clear on read, compare channels on write
            if (ack_go_w && ctrl_r.fast_flag_clear && hit_chan_w &&
                (we_i == capture_sel_r[chan_w])) begin
                chan_clr_r[chan_w] <= 1'b1; // [R10]
            end
        end
    end

    assign chan_flag_clr_o = chan_clr_r;
    assign accum_flag_clr_o = acc_clr_r;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_sel_r <= toc_pkg::RST_BYTE;
            ch7_override_mask_r <= toc_pkg::RST_BYTE;
            ch7_data_bits_r <= toc_pkg::RST_BYTE;
            overflow_toggle_bits_r <= toc_pkg::RST_BYTE;
            action_r <= {toc_pkg::RST_BYTE, toc_pkg::RST_BYTE};
            prescale_r <= toc_pkg::RST_PRESCALE;
            ctrl_r <= '0;
            irq_mask_r <= '0;
        end else if (wr_w) begin
            if (hit_cap_sel_w) capture_sel_r <= dat_i[7:0];
            if (hit_mask_w) ch7_override_mask_r <= dat_i[7:0];
            if (hit_data_w) ch7_data_bits_r <= dat_i[7:0];
            if (hit_tov_w) overflow_toggle_bits_r <= dat_i[7:0];
            if (hit_act_hi_w) action_r[15:8] <= dat_i[7:0];
            if (hit_act_lo_w) action_r[7:0] <= dat_i[7:0];
            if (hit_presc_w) prescale_r <= dat_i[2:0];
            if (hit_ctrl_w) ctrl_r <= dat_i[7:4]; // Low nibble reserved, reads zero
            if (hit_imask_w) irq_mask_r <= dat_i[toc_pkg::IRQ_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // Compare output actions
    // ------------------------------------------------------------
    wire [7:0] force_w = (wr_w && hit_force_w) ? dat_i[7:0] : 8'h00;
    wire ch7_win_w = compare_hit_i[7] && capture_sel_r[7]; // [R01]
    logic [7:0] line_nxt;

    // Action applied to one line for a mode/level pair
    function automatic logic act_apply(input logic [1:0] act, input logic cur);
        case (toc_pkg::toc_action_t'(act))
            toc_pkg::ACT_TOGGLE: act_apply = !cur; // [R15]
            toc_pkg::ACT_CLEAR: act_apply = 1'b0; // [R15]
            toc_pkg::ACT_SET: act_apply = 1'b1; // [R15]
            default: act_apply = cur; // Disconnected: line holds
        endcase
    endfunction

    // Priority per channel: ch7 override, overflow toggle, force, compare
    always_comb begin
        line_nxt = compare_output_line_r;
        for (int i = 0; i < 8; i++) begin
            if (!capture_sel_r[i]) begin
                line_nxt[i] = compare_output_line_r[i]; // Capture channel: idle
            end else if (ch7_win_w && ch7_override_mask_r[i]) begin
                line_nxt[i] = ch7_data_bits_r[i]; // [R01] [R18] [R13]
            end else if (wrap_w && overflow_toggle_bits_r[i]) begin
                line_nxt[i] = !compare_output_line_r[i]; // [R13]
            end else if (force_w[i] || compare_hit_i[i]) begin
                line_nxt[i] = act_apply(action_r[2*i +: 2], compare_output_line_r[i]); // [R15]
            end
        end
    end

    // Output lines
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_output_line_r <= toc_pkg::RST_BYTE;
        end else begin
            compare_output_line_r <= line_nxt;
        end
    end

    // Output compare pin drives its line when mode or level is set, or ch7 mask claims it
    logic [7:0] drive_w;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            drive_w[i] = capture_sel_r[i] && ((action_r[2*i +: 2] != 2'b00) ||
                         ch7_override_mask_r[i]); // [R14] [R16]
        end
    end

    assign pin_o = compare_output_line_r;
    assign pin_oe_n_o = ~drive_w; // [R14]

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic [toc_pkg::IRQ_BITS-1:0] irq_set_w;
    logic [toc_pkg::IRQ_BITS-1:0] irq_clr_w;
    assign irq_set_w[toc_pkg::IRQ_OVF_BIT] = wrap_w;
    assign irq_set_w[toc_pkg::IRQ_CH7_BIT] = ch7_win_w;
    assign irq_clr_w = (wr_w && hit_stat_w) ? dat_i[toc_pkg::IRQ_BITS-1:0] : '0;

    // Write one clears; a new event in the same cycle keeps its bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_set_w;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Ack one cycle after the request; read data captured at the same edge.
    // A whole-word read of the counter gives both bytes from one instant. [R03]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= take_w;
            if (take_w) begin
                dat_r <= rd_w;
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign count_o = free_counter_r;
    assign count_tick_o = cnt_step_w;

endmodule

// [hw/toc_pkg.sv]
// Shared constants and types for the timer counter and output control block
package toc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CAPTURE_SEL = 6'h00; // Capture/compare select per channel
    localparam logic [5:0] IDX_FORCE = 6'h01; // Force compare action, reads zero
    localparam logic [5:0] IDX_CH7_MASK = 6'h02; // ch7_override_mask
    localparam logic [5:0] IDX_CH7_DATA = 6'h03; // compare7_data_reg
    localparam logic [5:0] IDX_COUNT_HIGH = 6'h04; // count_high
    localparam logic [5:0] IDX_COUNT_LOW = 6'h05; // count_low
    localparam logic [5:0] IDX_SYS_CTRL1 = 6'h06; // system_control_one
    localparam logic [5:0] IDX_OVF_TOGGLE = 6'h07; // overflow_toggle_reg
    localparam logic [5:0] IDX_ACTION_HI = 6'h08; // output_action_hi, channels 7..4
    localparam logic [5:0] IDX_ACTION_LO = 6'h09; // output_action_lo, channels 3..0
    localparam logic [5:0] IDX_PRESCALE = 6'h0d; // Prescaler select in bits 2:0
    localparam logic [5:0] IDX_OVF_FLAG = 6'h0f; // Overflow flag in bit 7
    localparam logic [5:0] IDX_CHAN_FIRST = 6'h10; // First channel word register byte
    localparam logic [5:0] IDX_CHAN_LAST = 6'h1f; // Last channel word register byte
    localparam logic [5:0] IDX_ACC_FLAG = 6'h21; // accum_flag_reg, held elsewhere
    localparam logic [5:0] IDX_ACC_CNT_HI = 6'h22; // accum_count high byte
    localparam logic [5:0] IDX_ACC_CNT_LO = 6'h23; // accum_count low byte
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30; // Sticky event bits, write one to clear
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31; // Interrupt mask, same layout
    localparam logic [5:0] IDX_COUNT_WORD = 6'h32; // Whole counter in one access

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TIMER_ON_BIT = 7; // system_control_one: timer_on
    localparam int STOP_WAIT_BIT = 6; // system_control_one: stop_in_wait
    localparam int STOP_FRZ_BIT = 5; // system_control_one: stop_in_freeze
    localparam int FAST_CLR_BIT = 4; // system_control_one: fast_flag_clear
    localparam int OVF_FLAG_BIT = 7; // Overflow flag position in its register
    localparam int IRQ_OVF_BIT = 0; // Interrupt status: counter overflow
    localparam int IRQ_CH7_BIT = 1; // Interrupt status: channel 7 compare
    localparam int IRQ_BITS = 2; // Number of interrupt sources

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00; // All control bytes clear at reset
    localparam logic [15:0] RST_COUNT = 16'h0000; // Counter starts at zero
    localparam logic [15:0] COUNT_TOP = 16'hffff; // Last value before wrap
    localparam logic [2:0] RST_PRESCALE = 3'h0; // Divide by one after reset
    localparam int ACCUM_DIV = 64; // Pulse accumulator clock divider
    localparam int PRESC_MAX_LOG = 7; // Largest prescale is two to the seventh

    // ------------------------------------------------------------
    // Compare action encoding (mode bit, level bit)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00, // Pin disconnected
        ACT_TOGGLE = 2'b01, // Toggle the line
        ACT_CLEAR = 2'b10, // Drive the line to zero
        ACT_SET = 2'b11 // Drive the line to one
    } toc_action_t;

    // Timer control fields carried together
    typedef struct packed {
        logic timer_on;
        logic stop_in_wait;
        logic stop_in_freeze;
        logic fast_flag_clear;
    } toc_ctrl_t;

endpackage

// [hw/toc_prescaler.sv]
// Prescaler giving the counter tick and the divide-by-64 accumulator tick
`timescale 1ns/100ps

module toc_prescaler #(
    parameter int DIV_LOG_MAX = toc_pkg::PRESC_MAX_LOG
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i, // Prescaler runs only while high
    input wire logic [2:0] select_i, // Divide by two to this power
    // Ticks
    output logic tick_o, // One-cycle counter tick
    output logic div64_o // One-cycle tick every 64 clocks
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DIV_LOG_MAX != toc_pkg::PRESC_MAX_LOG) begin : g_bad_div
        $error("toc_prescaler: select field covers exactly seven stages");
    end

    // ------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------
    logic [DIV_LOG_MAX-1:0] stage_r; // Free divider stages
    logic [2:0] sel_r; // Selection in effect
    logic [DIV_LOG_MAX:0] mask_w; // Low bits that must be zero for a tick
    logic all_zero_w; // Whole chain at zero

    assign mask_w = (8'h01 << sel_r) - 8'h01;
    assign tick_o = run_i && ((stage_r & mask_w[DIV_LOG_MAX-1:0]) == '0);
    assign div64_o = run_i && (stage_r[5:0] == 6'h00);
    assign all_zero_w = (stage_r == '0);

    // Chain advances only while running; a stopped timer gives no ticks at all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_r <= '0;
        end else if (run_i) begin
            stage_r <= stage_r + 7'h01;
        end
    end

    // New ratio waits for the chain to pass zero, so no runt period appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_r <= toc_pkg::RST_PRESCALE;
        end else if (all_zero_w || !run_i) begin
            sel_r <= select_i;
        end
    end

endmodule

// [bench/toc_pad_model.sv]
// Timer port pads as seen from the board
`timescale 1ns/100ps
module toc_pad_model (
    input wire logic [7:0] pin_i,
    input wire logic [7:0] oe_n_i,
    output logic [7:0] pad_o
);
    // Released pads fall to the pull-down level
    assign pad_o = pin_i & ~oe_n_i;
endmodule

// [bench/toc_timer_asserts.sv]
// Port checks for the timer block
`timescale 1ns/100ps
module toc_timer_asserts (
    input wire logic clk_i, rst_i, cyc_i, stb_i, ack_o, test_mode_i, wait_mode_i,
    input wire logic [7:0] adr_i, compare_hit_i, chan_flag_clr_o, pin_o,
    input wire logic [31:0] dat_o,
    input wire logic accum_flag_clr_o, accum_run_o, count_tick_o,
    input wire logic [15:0] count_o
);
    logic [7:0] adr_q, hit_q;
    logic ack_q, tick_q;
    // Last-cycle copies of the causes
    always_ff @(posedge clk_i) begin
        adr_q <= adr_i;
        hit_q <= compare_hit_i;
        ack_q <= ack_o;
        tick_q <= count_tick_o;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_one: assert property (ack_o |=> !ack_o) else $error("ack too long");
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    chk_count_step: assert property (count_tick_o && !test_mode_i |=>
        count_o == $past(count_o) + 16'h0001) else $error("bad count step");
    chk_count_hold: assert property (!count_tick_o && !test_mode_i |=>
        $stable(count_o)) else $error("count moved");
    chk_dat_hold: assert property (!(cyc_i && stb_i) && !ack_o |=> $stable(dat_o))
        else $error("read data moved");
    chk_wait_run: assert property (!wait_mode_i |-> accum_run_o) else $error("run low");
    chk_chan_clear: assert property (chan_flag_clr_o != 8'h00 |-> ack_q &&
        adr_q[7:6] == 2'h1 && chan_flag_clr_o == (8'h01 << adr_q[5:3])) else $error("bad clr");
    chk_accum_clear: assert property (accum_flag_clr_o |-> ack_q &&
        adr_q[7:3] == 5'h11) else $error("bad accum clear");
    chk_pin_cause: assert property (pin_o != $past(pin_o) |->
        hit_q != 8'h00 || ack_q || tick_q) else $error("pin moved alone");
    cover property (compare_hit_i[7]);
    cover property (count_tick_o && count_o == 16'hffff);
    cover property (!ack_o ##1 ack_o);
endmodule
bind toc_timer toc_timer_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .test_mode_i(test_mode_i), .wait_mode_i(wait_mode_i),
    .adr_i(adr_i), .compare_hit_i(compare_hit_i), .chan_flag_clr_o(chan_flag_clr_o),
    .pin_o(pin_o), .dat_o(dat_o), .accum_flag_clr_o(accum_flag_clr_o),
    .accum_run_o(accum_run_o), .count_tick_o(count_tick_o), .count_o(count_o));

// [bench/toc_timer_tb_top.sv]
// Self-checking bench for the timer block
`timescale 1ns/100ps
module toc_timer_tb_top;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, tm = 1'h0;
    logic [7:0] adr = 8'h00, hit = 8'h00, chan_clr, pin, oe_n, pad;
    logic [31:0] dat = 32'h0, q, q2, rd;
    logic wm = 1'h0, fm = 1'h0;
    logic ack, acc_clr, irq, atk, arun;
    int bad_count = 0, checked = 0;
    logic [5:0] r_idx [7] = '{toc_pkg::IDX_CH7_DATA, toc_pkg::IDX_OVF_TOGGLE,
        toc_pkg::IDX_ACTION_HI, toc_pkg::IDX_ACTION_LO, toc_pkg::IDX_FORCE,
        toc_pkg::IDX_COUNT_LOW, 6'h3f};
    logic [7:0] r_wr [7] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'hff, 8'h77, 8'h99};
    logic [7:0] r_rd [7] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h00, 8'h00, 8'h00};
    toc_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .dat_o(rd), .ack_o(ack), .test_mode_i(tm),
        .wait_mode_i(wm), .freeze_mode_i(fm), .compare_hit_i(hit),
        .chan_flag_clr_o(chan_clr), .accum_flag_clr_o(acc_clr), .accum_tick_o(atk),
        .accum_run_o(arun), .count_o(), .count_tick_o(), .pin_o(pin), .pin_oe_n_o(oe_n),
        .irq_o(irq));
    toc_pad_model u_pad (.pin_i(pin), .oe_n_i(oe_n), .pad_o(pad));
    always #50 clk_i = ~clk_i;
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic [5:0] i, input logic w, input logic [15:0] d);
        int n = 0;
        cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= {i, 2'h0}; dat <= {16'h0, d};
        do begin @(posedge clk_i); n++; end while (ack !== 1'h1 && n < 50);
        if (n >= 50) begin bad_count++; end_of_test(); end
        q = rd;
        cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic pulse(input logic [7:0] v);
        hit <= v;
        @(posedge clk_i);
        hit <= 8'h00;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk(oe_n, 32'hff);
        chk(atk, 32'h0);
        for (int k = 0; k < 7; k++) begin
            wb(r_idx[k], 1'h1, {8'h0, r_wr[k]});
            wb(r_idx[k], 1'h0, 16'h0);
            chk(q, {24'h0, r_rd[k]});
        end
        // Channel 7 override on the low nibble, then each action code
        wb(toc_pkg::IDX_CAPTURE_SEL, 1'h1, 16'hff);
        wb(toc_pkg::IDX_CH7_MASK, 1'h1, 16'h0f);
        wb(toc_pkg::IDX_ACTION_HI, 1'h1, 16'h00);
        wb(toc_pkg::IDX_ACTION_LO, 1'h1, 16'hff);
        wb(toc_pkg::IDX_OVF_TOGGLE, 1'h1, 16'h00);
        pulse(8'h81);
        chk(pin, 32'h05);
        chk(oe_n, 32'hf0);
        wb(toc_pkg::IDX_CH7_MASK, 1'h1, 16'h00);
        wb(toc_pkg::IDX_ACTION_LO, 1'h1, 16'h1b);
        pulse(8'h0f);
        chk(pad, 32'h01);
        chk(oe_n, 32'hf8);
        // Fast clears with the timer stopped
        wb(toc_pkg::IDX_SYS_CTRL1, 1'h1, 16'h10);
        wb(toc_pkg::IDX_CHAN_FIRST, 1'h1, 16'h0);
        chk(chan_clr, 32'h01);
        wb(toc_pkg::IDX_ACC_CNT_HI, 1'h0, 16'h0);
        chk(acc_clr, 32'h1);
        // Load near the top, run across the wrap, stop
        tm <= 1'h1;
        wb(toc_pkg::IDX_COUNT_WORD, 1'h1, 16'hfffe);
        tm <= 1'h0;
        wb(toc_pkg::IDX_OVF_TOGGLE, 1'h1, 16'h08);
        wb(toc_pkg::IDX_SYS_CTRL1, 1'h1, 16'h90);
        // Three steps before the stop lands; fast clear off keeps the flag
        wb(toc_pkg::IDX_SYS_CTRL1, 1'h1, 16'h00);
        wb(toc_pkg::IDX_COUNT_WORD, 1'h0, 16'h0);
        q2 = q;
        chk(q2, 32'h1);
        chk(pin, 32'h09);
        wb(toc_pkg::IDX_COUNT_WORD, 1'h0, 16'h0);
        chk(q, q2);
        chk(irq, 32'h0);
        wb(toc_pkg::IDX_OVF_FLAG, 1'h0, 16'h0);
        chk(q, 32'h80);
        wb(toc_pkg::IDX_IRQ_MASK, 1'h1, 16'h1);
        chk(irq, 32'h1);
        // Wait stop halts the accumulator too, freeze stop only the counter
        wm <= 1'h1;
        wb(toc_pkg::IDX_SYS_CTRL1, 1'h1, 16'hf0);
        chk(arun, 32'h0);
        chk(atk, 32'h0);
        wm <= 1'h0;
        fm <= 1'h1;
        @(posedge clk_i);
        chk(arun, 32'h1);
        wb(toc_pkg::IDX_SYS_CTRL1, 1'h1, 16'h10);
        fm <= 1'h0;
        wb(toc_pkg::IDX_COUNT_LOW, 1'h0, 16'h0);
        chk(q, 32'h01);
        wb(toc_pkg::IDX_OVF_FLAG, 1'h0, 16'h0);
        chk(q, 32'h00);
        wb(toc_pkg::IDX_IRQ_STATUS, 1'h1, 16'h1);
        chk(irq, 32'h0);
        end_of_test();
    end
endmodule
